/* logic/flag_ctrl_regs.svh */
// timing and field constants for the host-side flag controller
// assumes a 25 MHz system clock driving one port of the shared-flag device
`ifndef FLAG_CTRL_REGS_SVH
`define FLAG_CTRL_REGS_SVH
`define CLK_PERIOD_NS 40
`define SETUP_TIME_NS 80
`define PULSE_TIME_NS 80
`define GAP_TIME_NS 40
`define SETUP_CYCLES ((`SETUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CYCLES ((`PULSE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_CYCLES ((`GAP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 4
`define DATA_W 16
`define IDX_W 3
`define FLAG_COUNT 8
`define CNT_ZERO 4'h0
`define DATA_ZERO 16'h0000
`define DATA_ONES 16'hffff
`define IDX_ZERO 3'h0
`define IDX_LAST 3'h7
`define OP_W 2
`define OP_RELEASE 2'h0
`define OP_CLAIM 2'h1
`define OP_POLL 2'h2
`define OP_INIT 2'h3
`define DATA_BIT0 0
`endif

/* logic/flag_ctrl_pkg.sv */
// types for the host-side flag controller
// assumes flag_ctrl_regs.svh is included before use of the constants
package flag_ctrl_pkg;
    typedef enum logic [6:0] {
        st_idle = 7'b000_0001,
        st_wsetup = 7'b000_0010,
        st_wpulse = 7'b000_0100,
        st_gap = 7'b000_1000,
        st_rsetup = 7'b001_0000,
        st_rhold = 7'b010_0000,
        st_done = 7'b100_0000
    } ctrl_state_t;
endpackage

/* logic/cycle_timer.sv */
// down-counting phase timer for the access sequencer
// assumes load and count requests come from logic on clk_sys
`timescale 1ns/1ns
`default_nettype none
`include "flag_ctrl_regs.svh"
module cycle_timer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // control
    input wire logic load,
    input wire logic [`CNT_W-1:0] load_val,
    // status
    output logic expired
);
    logic [`CNT_W-1:0] count_ff;

    // ----------------------------------------
    // count down toward zero after each load
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            count_ff <= `CNT_ZERO;
        end else if (load) begin
            count_ff <= load_val;
        end else if (count_ff != `CNT_ZERO) begin
            count_ff <= count_ff - 1'b1;
        end
    end

    assign expired = (count_ff == `CNT_ZERO);
endmodule
`default_nettype wire

/* logic/flag_port_host.sv */
// host controller for one port of a dual-port shared-flag device
// assumes the device is asynchronous and its data pins return to this clock domain
// Behaviour
// RULE_01: eight flags in separate select space
// RULE_02: write zero requests, write one releases
// RULE_03: flag select low, then static-ram style access
// RULE_04: only three low address lines pick flag
// RULE_05: only data bit zero is written
// RULE_06: free flag taken reads zero here
// RULE_07: owner writing one frees the flag
// RULE_08: loser request waits in its latch
// RULE_09: read value replicated on all bits
// RULE_10: read held while select and enable active
// RULE_11: pending request takes token on release
// RULE_12: earlier request wins, ties to one
// RULE_13: write zero first, then read back
// RULE_14: failed request followed by poll or release
// RULE_15: drop enable between polling reads
// RULE_16: write one to all flags at startup
// RULE_17: write bit zero, read all sixteen lines
// RULE_18: fixed priority for exact ties
// RULE_19: flags undefined at power up
`timescale 1ns/1ns
`default_nettype none
`include "flag_ctrl_regs.svh"
module flag_port_host
    import flag_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // user command
    input wire logic cmd_valid,
    input wire logic [`OP_W-1:0] cmd_op,
    input wire logic [`IDX_W-1:0] cmd_index,
    output logic cmd_ready,
    // user result
    output logic rsp_valid,
    output logic rsp_owned,
    output logic rsp_clean,
    // device pins
    output logic flag_space_select_n,
    output logic [`IDX_W-1:0] flag_index_lines,
    output logic output_enable_n,
    output logic write_n,
    input wire logic [`DATA_W-1:0] port_data_lines_in,
    output logic [`DATA_W-1:0] port_data_lines_out,
    output logic port_data_lines_oe
);
    ctrl_state_t state_ff, nxt_state;
    logic [`OP_W-1:0] op_ff;
    logic [`IDX_W-1:0] idx_ff;
    logic wbit_ff;
    logic [`DATA_W-1:0] din_meta_ff, din_sync_ff;
    logic owned_ff, clean_ff, rsp_valid_ff;
    logic tmr_load, tmr_exp;
    logic [`CNT_W-1:0] tmr_val;
    logic sweep_step;

    // a flag is owned when every line reads zero; mixed lines mean a bad bus
    function automatic logic all_zero(input logic [`DATA_W-1:0] d);
        all_zero = (d == `DATA_ZERO);
    endfunction

    function automatic logic all_same(input logic [`DATA_W-1:0] d);
        all_same = (d == `DATA_ZERO) || (d == `DATA_ONES);
    endfunction

    // ----------------------------------------
    // phase timer
    // ----------------------------------------
    cycle_timer u_timer (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .load(tmr_load),
        .load_val(tmr_val),
        .expired(tmr_exp)
    );

    // ----------------------------------------
    // synchronise the device data lines
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            din_meta_ff <= `DATA_ZERO;
            din_sync_ff <= `DATA_ZERO;
        end else begin
            din_meta_ff <= port_data_lines_in;
            din_sync_ff <= din_meta_ff;
        end
    end

    // ----------------------------------------
    // sequencer state
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        tmr_load = 1'b0;
        tmr_val = `CNT_ZERO;
        case (state_ff)
            st_idle: begin
                if (cmd_valid) begin
                    tmr_load = 1'b1;
                    tmr_val = `CNT_W'(`SETUP_CYCLES);
                    // a poll skips the write; others write first, and only a claim then reads back [RULE_13]
                    nxt_state = (cmd_op == `OP_POLL) ? st_rsetup : st_wsetup;
                end
            end
            st_wsetup: begin
                if (tmr_exp) begin
                    tmr_load = 1'b1;
                    tmr_val = `CNT_W'(`PULSE_CYCLES);
                    nxt_state = st_wpulse;
                end
            end
            st_wpulse: begin
                if (tmr_exp) begin
                    tmr_load = 1'b1;
                    tmr_val = `CNT_W'(`GAP_CYCLES);
                    nxt_state = st_gap;
                end
            end
            st_gap: begin
                if (tmr_exp) begin
                    tmr_load = 1'b1;
                    tmr_val = `CNT_W'(`SETUP_CYCLES);
                    if (op_ff == `OP_CLAIM) begin
                        nxt_state = st_rsetup; // read back after the request [RULE_13]
                    end else if (op_ff == `OP_INIT && idx_ff != `IDX_LAST) begin
                        nxt_state = st_wsetup; // next flag of the startup sweep [RULE_16]
                    end else begin
                        nxt_state = st_done;
                    end
                end
            end
            st_rsetup: begin
                // sync delay covers two more edges before sampling
                if (tmr_exp) begin
                    tmr_load = 1'b1;
                    tmr_val = `CNT_W'(`GAP_CYCLES);
                    nxt_state = st_rhold;
                end
            end
            st_rhold: begin
                // select drops after the read so the next poll re-latches [RULE_15]
                if (tmr_exp) begin
                    nxt_state = st_done;
                end
            end
            st_done: begin
                nxt_state = st_idle;
            end
            default: begin
                nxt_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= st_idle;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------
    // command capture and sweep index
    // ----------------------------------------
    // end of one init flag; the index must step together with the next select
    assign sweep_step = (state_ff == st_gap) && tmr_exp && (op_ff == `OP_INIT);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            op_ff <= `OP_RELEASE;
            idx_ff <= `IDX_ZERO;
            wbit_ff <= 1'b1;
        end else if (state_ff == st_idle && cmd_valid) begin
            op_ff <= cmd_op;
            // init sweeps from flag zero; no power-up state is trusted [RULE_19]
            idx_ff <= (cmd_op == `OP_INIT) ? `IDX_ZERO : cmd_index;
            wbit_ff <= (cmd_op != `OP_CLAIM); // zero requests, one releases [RULE_02]
        end else if (sweep_step) begin
            idx_ff <= idx_ff + 1'b1;
        end
    end

    // ----------------------------------------
    // device pins
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            flag_space_select_n <= 1'b1;
            flag_index_lines <= `IDX_ZERO;
            output_enable_n <= 1'b1;
            write_n <= 1'b1;
            port_data_lines_out <= `DATA_ONES;
            port_data_lines_oe <= 1'b0;
        end else begin
            // select only the flag space [RULE_01] [RULE_03]
            flag_space_select_n <= !(nxt_state == st_wsetup || nxt_state == st_wpulse ||
                nxt_state == st_rsetup);
            // only three index lines leave this controller [RULE_04]
            // index is set with the select edge, so it never moves mid-access
            if (state_ff == st_idle) begin
                flag_index_lines <= (cmd_op == `OP_INIT) ? `IDX_ZERO : cmd_index;
            end else if (sweep_step) begin
                flag_index_lines <= idx_ff + 1'b1;
            end else begin
                flag_index_lines <= idx_ff;
            end
            output_enable_n <= !(nxt_state == st_rsetup);
            write_n <= !(nxt_state == st_wpulse);
            // value rides on bit zero; upper lines mirror it harmlessly [RULE_05] [RULE_17]
            port_data_lines_out <= {`DATA_W{(state_ff == st_idle) ? (cmd_op != `OP_CLAIM) : wbit_ff}};
            port_data_lines_oe <= (nxt_state == st_wsetup || nxt_state == st_wpulse);
        end
    end

    // ----------------------------------------
    // read-back result
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            owned_ff <= 1'b0;
            clean_ff <= 1'b0;
        end else if (state_ff == st_rsetup && tmr_exp) begin
            // device holds its latched value while select and enable stay low [RULE_10]
            owned_ff <= all_zero(din_sync_ff); // zero here means token ours [RULE_06] [RULE_09]
            clean_ff <= all_same(din_sync_ff);
        end else if (state_ff == st_idle && cmd_valid && cmd_op != `OP_POLL) begin
            owned_ff <= 1'b0;
            clean_ff <= 1'b1;
        end
    end

    // a lost claim stays pending in the device; user must poll or release [RULE_08] [RULE_14]
    // on release the device may hand over to a waiter [RULE_07] [RULE_11] [RULE_12] [RULE_18]
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_valid_ff <= 1'b0;
        end else begin
            rsp_valid_ff <= (nxt_state == st_done);
        end
    end

    assign cmd_ready = (state_ff == st_idle);
    assign rsp_valid = rsp_valid_ff;
    assign rsp_owned = owned_ff;
    assign rsp_clean = clean_ff;
endmodule
`default_nettype wire

/* sim/flag_port_chk.sv */
// port checker for the host flag controller
// assumes it is bound to flag_port_host
`timescale 1ns/1ns
`default_nettype none
`include "flag_ctrl_regs.svh"
module flag_port_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // user side
    input wire logic cmd_valid,
    input wire logic [`OP_W-1:0] cmd_op,
    input wire logic [`IDX_W-1:0] cmd_index,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic rsp_owned,
    input wire logic rsp_clean,
    // device side
    input wire logic flag_space_select_n,
    input wire logic [`IDX_W-1:0] flag_index_lines,
    input wire logic output_enable_n,
    input wire logic write_n,
    input wire logic [`DATA_W-1:0] port_data_lines_in,
    input wire logic [`DATA_W-1:0] port_data_lines_out,
    input wire logic port_data_lines_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic take;
    // accepted command, the cause of each bus sequence
    assign take = cmd_valid && cmd_ready;
    property p_wr_sel; !write_n |-> !flag_space_select_n && port_data_lines_oe && output_enable_n; endproperty
    a_wr_sel: assert property (p_wr_sel) else $error("write strobe without select");
    property p_rep; port_data_lines_oe |-> port_data_lines_out inside {16'h0000, 16'hffff}; endproperty
    a_rep: assert property (p_rep) else $error("written value not on all lines");
    property p_idx; !flag_space_select_n && $past(!flag_space_select_n) |-> $stable(flag_index_lines); endproperty
    a_idx: assert property (p_idx) else $error("index moved under select");
    property p_claim; take && cmd_op == `OP_CLAIM |-> ##[1:8] (!write_n && port_data_lines_out == 16'h0000); endproperty
    a_claim: assert property (p_claim) else $error("claim wrote no zero");
    property p_rel; take && cmd_op == `OP_RELEASE |-> ##[1:8] (!write_n && port_data_lines_out == 16'hffff); endproperty
    a_rel: assert property (p_rel) else $error("release wrote no one");
    property p_rd; take && cmd_op == `OP_CLAIM |-> ##[4:14] !output_enable_n; endproperty
    a_rd: assert property (p_rd) else $error("claim not read back");
    property p_poll; take && cmd_op == `OP_POLL |-> ##1 (write_n && !port_data_lines_oe) [*6]; endproperty
    a_poll: assert property (p_poll) else $error("poll wrote the flag");
    property p_end; rsp_valid |-> flag_space_select_n && output_enable_n ##1 !rsp_valid && cmd_ready; endproperty
    a_end: assert property (p_end) else $error("read held past result");
    property p_own; rsp_valid && rsp_owned |-> rsp_clean; endproperty
    a_own: assert property (p_own) else $error("owned from mixed read");
endmodule
`default_nettype wire

/* sim/flag_dev_model.sv */
// behavioural shared-flag device, two ports
// assumes left pins come from the controller, right pins from the bench
`timescale 1ns/1ns
`default_nettype none
module flag_dev_model (
    // left port
    input wire logic l_sel_n,
    input wire logic [2:0] l_idx,
    input wire logic l_oe_n,
    input wire logic l_we_n,
    input wire logic [15:0] l_d,
    output logic [15:0] l_q,
    // right port
    input wire logic r_sel_n,
    input wire logic [2:0] r_idx,
    input wire logic r_oe_n,
    input wire logic r_we_n,
    input wire logic [15:0] r_d,
    output logic [15:0] r_q
);
    // eight request latch pairs and owners, 0 free 1 left 2 right
    logic [7:0] req_l = 8'hff;
    logic [7:0] req_r = 8'h00;
    logic [1:0] own [8] = '{default: 2'd2};
    logic [15:0] hold_l = 16'hffff;
    logic [15:0] hold_r = 16'hffff;
    // power-up state is hostile: right holds every token
    // release frees or hands over; left wins exact ties
    task automatic settle();
        for (int k = 0; k < 8; k++) begin
            if ((own[k] == 2'd1 && req_l[k]) || (own[k] == 2'd2 && req_r[k])) own[k] = 2'd0;
            if (own[k] == 2'd0) own[k] = !req_l[k] ? 2'd1 : (!req_r[k] ? 2'd2 : 2'd0);
        end
    endtask
    // request taken from bit zero as the strobe falls
    always @(negedge l_we_n) if (!l_sel_n) begin
        req_l[l_idx] = l_d[0];
        settle();
    end
    always @(negedge r_we_n) if (!r_sel_n) begin
        req_r[r_idx] = r_d[0];
        settle();
    end
    // value frozen while select and enable stay low, spread over all lines
    always @(negedge l_sel_n or negedge l_oe_n) if (!l_sel_n && !l_oe_n) hold_l = {16{own[l_idx] != 2'd1}};
    always @(negedge r_sel_n or negedge r_oe_n) if (!r_sel_n && !r_oe_n) hold_r = {16{own[r_idx] != 2'd2}};
    // a released bus shows the inverse, so stale data cannot pass
    assign l_q = (!l_sel_n && !l_oe_n) ? hold_l : ~hold_l;
    assign r_q = (!r_sel_n && !r_oe_n) ? hold_r : ~hold_r;
endmodule
`default_nettype wire

/* sim/test_dual_port_semaphore_flags.sv */
// bench for the host flag controller against a two-port device model
// assumes the bench plays the right-side processor itself
`timescale 1ns/1ns
`default_nettype none
`include "flag_ctrl_regs.svh"
module test_dual_port_semaphore_flags;
    logic clk_sys = 0;
    logic sys_rst = 1;
    logic cmd_valid = 0;
    logic [1:0] cmd_op = 0;
    logic [2:0] cmd_index = 0;
    logic r_sel_n = 1;
    logic r_oe_n = 1;
    logic r_we_n = 1;
    logic [2:0] r_idx = 0;
    logic [15:0] r_d = 16'hffff;
    wire logic cmd_ready, rsp_valid, rsp_owned, rsp_clean, sel_n, oe_n, we_n, d_oe;
    wire logic [2:0] idx;
    wire logic [15:0] d_in, d_out, r_q;
    int mismatches = 0;
    int checked = 0;
    always #20 clk_sys = ~clk_sys;
    flag_port_host dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_index(cmd_index), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_owned(rsp_owned),
        .rsp_clean(rsp_clean), .flag_space_select_n(sel_n), .flag_index_lines(idx), .output_enable_n(oe_n),
        .write_n(we_n), .port_data_lines_in(d_in), .port_data_lines_out(d_out), .port_data_lines_oe(d_oe));
    flag_dev_model dev_u (.l_sel_n(sel_n), .l_idx(idx), .l_oe_n(oe_n), .l_we_n(we_n), .l_d(d_out), .l_q(d_in),
        .r_sel_n(r_sel_n), .r_idx(r_idx), .r_oe_n(r_oe_n), .r_we_n(r_we_n), .r_d(r_d), .r_q(r_q));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask
    // one command, waits a bounded time for the result pulse
    task automatic cmd(input logic [1:0] op, input logic [2:0] ix);
        int n = 0;
        cmd_valid <= 1;
        cmd_op <= op;
        cmd_index <= ix;
        @(posedge clk_sys);
        cmd_valid <= 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rsp_valid !== 1'b1 && n < 400);
        chk_bit(rsp_valid, 1'b1);
    endtask
    // right-side access: write bit b, or read and compare
    task automatic rside(input logic [2:0] ix, input logic w, input logic b, input logic [15:0] exp);
        r_sel_n <= 0;
        r_idx <= ix;
        r_d <= {16{b}};
        @(posedge clk_sys);
        if (w) r_we_n <= 0;
        else r_oe_n <= 0;
        repeat (2) @(posedge clk_sys);
        if (!w) chk(r_q, exp);
        r_we_n <= 1;
        r_oe_n <= 1;
        r_sel_n <= 1;
        @(posedge clk_sys);
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_init();
        cmd(`OP_INIT, 3'h6); // index is ignored, sweep starts at zero
        chk_bit(rsp_clean, 1'b1);
        for (int k = 0; k < 8; k++) rside(k[2:0], 1, 1, 0);
        for (int k = 0; k < 8; k++) begin
            cmd(`OP_POLL, k[2:0]);
            chk_bit(rsp_owned, 1'b0);
            rside(k[2:0], 0, 0, 16'hffff);
        end
        $display("init test done");
    endtask
    task automatic t_pass();
        cmd(`OP_CLAIM, 3'h5);
        chk_bit(rsp_owned, 1'b1);
        rside(3'h5, 0, 0, 16'hffff);
        rside(3'h5, 1, 0, 0);
        rside(3'h5, 0, 0, 16'hffff);
        cmd(`OP_RELEASE, 3'h5);
        rside(3'h5, 0, 0, 16'h0000);
        cmd(`OP_POLL, 3'h5);
        chk_bit(rsp_owned, 1'b0);
        rside(3'h5, 1, 1, 0);
        rside(3'h5, 0, 0, 16'hffff);
        $display("handover test done");
    endtask
    task automatic t_fail();
        rside(3'h2, 1, 0, 0);
        cmd(`OP_CLAIM, 3'h2);
        chk_bit(rsp_owned, 1'b0);
        cmd(`OP_RELEASE, 3'h2);
        rside(3'h2, 1, 1, 0);
        rside(3'h2, 0, 0, 16'hffff);
        cmd(`OP_CLAIM, 3'h2);
        chk_bit(rsp_owned, 1'b1);
        $display("refused claim test done");
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        chk_bit(sel_n, 1'b1);
        sys_rst <= 0;
        @(posedge clk_sys);
        t_init();
        t_pass();
        t_fail();
        complete_run();
    end
    // watchdog, far beyond the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        complete_run();
    end
endmodule
bind flag_port_host flag_port_chk chk_u (.clk_sys, .sys_rst, .cmd_valid, .cmd_op, .cmd_index, .cmd_ready,
    .rsp_valid, .rsp_owned, .rsp_clean, .flag_space_select_n, .flag_index_lines, .output_enable_n, .write_n,
    .port_data_lines_in, .port_data_lines_out, .port_data_lines_oe);
`default_nettype wire
